// ==== shared/iap_consts.svh ====
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH

// register map inside data memory sector 1
`define IAP_SECTOR 8'h01
`define IAP_OFF_CTRL 8'h43
`define IAP_OFF_KEY 8'h44
`define IAP_OFF_CLR 8'h45
`define IAP_OFF_ADDR_LO 8'h46
`define IAP_OFF_ADDR_HI 8'h47
`define IAP_OFF_DATA0 8'h48
`define IAP_OFF_DATA1 8'h4A
`define IAP_OFF_DATA3H 8'h4F

// control register fields
`define IAP_BIT_WEN_STAT 7
`define IAP_MODE_HI 6
`define IAP_MODE_LO 4
`define IAP_BIT_UNLOCK_EN 3
`define IAP_BIT_WR_TRIG 2
`define IAP_BIT_RD_EN 1
`define IAP_BIT_RD_TRIG 0
`define IAP_BIT_CLR_TRIG 0

`define IAP_MODE_WRITE 3'h0
`define IAP_MODE_ERASE 3'h1
`define IAP_MODE_READ 3'h3
`define IAP_MODE_UNLOCK 3'h6

`define IAP_RESET_KEY 8'h55
`define IAP_BYTE_RESET 8'h00
`define IAP_ADDR_HI_BITS 5

// unlock pattern, written to word1 low .. word3 high
`define IAP_PAT0 8'h00
`define IAP_PAT1 8'h04
`define IAP_PAT2 8'h0D
`define IAP_PAT3 8'h09
`define IAP_PAT4 8'hC3
`define IAP_PAT5 8'h40
`define IAP_PAT_LAST 3'h5

// unlock window: a longest time, so rounded down
`define IAP_UNLOCK_NS 300000
`define IAP_CLK_NS 20
`define IAP_UNLOCK_CYC (`IAP_UNLOCK_NS / `IAP_CLK_NS)

// host APB map
`define HOST_OFF_CMD 12'h000
`define HOST_OFF_STATUS 12'h004
`define HOST_OFF_IRQ_STAT 12'h008
`define HOST_OFF_IRQ_MASK 12'h00C
`define HOST_CMD_WR_BIT 24
`define HOST_EV_DONE 0
`define HOST_EV_CHIP_RST 1
`define HOST_EV_DROP 2
`define HOST_EV_BITS 3

`endif

// ==== shared/iap_pkg.sv ====
package iap_pkg;

  typedef enum logic [1:0] {
    U_IDLE = 2'b01,
    U_RUN = 2'b10
  } unlock_state_t;

  typedef enum logic [1:0] {
    O_IDLE = 2'b01,
    O_WAIT = 2'b10
  } op_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WAIT = 4'b0010,
    H_ISSUE = 4'b0100,
    H_CAPT = 4'b1000
  } host_state_t;

endpackage

// ==== shared/iap_link_if.sv ====
`timescale 1ns/1ns
interface iap_link_if;
  logic sel;
  logic wr;
  logic [7:0] sector;
  logic [7:0] offset;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic cpu_halt;
  logic chip_reset;

  modport dev (
    input sel,
    input wr,
    input sector,
    input offset,
    input wdata,
    output rdata,
    output cpu_halt,
    output chip_reset
  );

  modport host (
    output sel,
    output wr,
    output sector,
    output offset,
    output wdata,
    input rdata,
    input cpu_halt,
    input chip_reset
  );
endinterface

// ==== src/iap_device.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "iap_consts.svh"

// What this block does
// - control registers at sector 1, 43H to 45H
// - software clearing status bit disables writing
// - only successful unlock sets write status
// - mode field selects write, erase, read, unlock
// - unlock enable plus mode 110 runs unlock
// - software must re-arm unlock after success, failure or timeout
// - write trigger cleared by hardware when done
// - read enable bit gates flash reads
// - read trigger cleared by hardware when done
// - key 55H written resets whole chip
// - buffer clear self-clears, upper bits read zero
// - small variant address high holds five bits
// - large variant address high holds six bits
// - word pair holds low then high byte
// - exact six-byte pattern enables writing
// - 300us timeout, unlock enable self-clears when an unlock run ends
// - halt processor while write or read trigger
module iap_device
  import iap_pkg::*;
#(
  parameter int ADDR_HI_BITS = `IAP_ADDR_HI_BITS,
  parameter int UNLOCK_CYC = `IAP_UNLOCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  iap_link_if.dev link,
  output logic [13:0] flash_addr,
  output logic [15:0] flash_wdata,
  output logic flash_write,
  output logic flash_erase,
  output logic flash_read,
  output logic flash_clear,
  input wire logic flash_done,
  input wire logic [15:0] flash_rdata
);

  localparam logic [5:0] HI_MASK = 6'((1 << ADDR_HI_BITS) - 1);

  logic wen_stat;
  logic [2:0] mode;
  logic unlock_en;
  logic wr_trig;
  logic rd_en;
  logic rd_trig;
  logic clr_trig;
  logic [7:0] key;
  logic [7:0] addr_lo;
  logic [5:0] addr_hi;
  logic [7:0] data [8];
  logic [7:0] rdata;
  logic halt;
  logic chip_rst;

  unlock_state_t ustate;
  logic [$clog2(UNLOCK_CYC+1)-1:0] ucnt;
  logic [2:0] uidx;
  logic unlock_ok;
  logic unlock_end;

  op_state_t ostate;
  op_state_t next_ostate;
  logic [2:0] op_kind;
  logic [2:0] next_op_kind;
  logic launch_wr;
  logic launch_er;
  logic launch_rd;
  logic launch_clr;
  logic end_wr;
  logic end_rd;
  logic end_clr;
  logic next_wr_trig;
  logic next_rd_trig;

  logic wr_hit;
  logic rd_hit;
  logic ctrl_wr;
  logic data_wr;
  logic [2:0] data_idx;
  logic [7:0] pat;

  assign wr_hit = link.sel & link.wr & (link.sector == `IAP_SECTOR);
  assign rd_hit = link.sel & ~link.wr & (link.sector == `IAP_SECTOR);
  assign ctrl_wr = wr_hit & (link.offset == `IAP_OFF_CTRL);
  assign data_wr = wr_hit & (link.offset >= `IAP_OFF_DATA0)
                 & (link.offset <= `IAP_OFF_DATA3H);
  assign data_idx = 3'(link.offset - `IAP_OFF_DATA0);

  assign link.rdata = rdata;
  assign link.cpu_halt = halt;
  assign link.chip_reset = chip_rst;
  assign flash_addr = {addr_hi, addr_lo};
  assign flash_wdata = {data[1], data[0]};

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 3'h0;
      rd_en <= 1'b0;
      key <= `IAP_BYTE_RESET;
      addr_lo <= `IAP_BYTE_RESET;
      addr_hi <= 6'h00;
    end else if (wr_hit) begin
      case (link.offset)
        `IAP_OFF_CTRL: begin
          mode <= link.wdata[`IAP_MODE_HI:`IAP_MODE_LO];
          rd_en <= link.wdata[`IAP_BIT_RD_EN];
        end
        `IAP_OFF_KEY: key <= link.wdata;
        `IAP_OFF_ADDR_LO: addr_lo <= link.wdata;
        `IAP_OFF_ADDR_HI: addr_hi <= link.wdata[5:0] & HI_MASK;
        default: begin
        end
      endcase
    end
  end

  // data word registers; read result lands in word 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        data[i] <= `IAP_BYTE_RESET;
      end
    end else if (end_rd && ostate == O_WAIT) begin
      data[0] <= flash_rdata[7:0];
      data[1] <= flash_rdata[15:8];
    end else if (data_wr) begin
      data[data_idx] <= link.wdata;
    end
  end

  // write status: set by unlock success only, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wen_stat <= 1'b0;
    end else if (unlock_ok) begin
      wen_stat <= 1'b1;
    end else if (ctrl_wr && !link.wdata[`IAP_BIT_WEN_STAT]) begin
      wen_stat <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_en <= 1'b0;
    end else if (ctrl_wr && link.wdata[`IAP_BIT_UNLOCK_EN]) begin
      unlock_en <= 1'b1;
    end else if (unlock_end) begin
      unlock_en <= 1'b0;
    end else if (ctrl_wr) begin
      unlock_en <= 1'b0;
    end
  end

  always_comb begin
    case (uidx)
      3'h0: pat = `IAP_PAT0;
      3'h1: pat = `IAP_PAT1;
      3'h2: pat = `IAP_PAT2;
      3'h3: pat = `IAP_PAT3;
      3'h4: pat = `IAP_PAT4;
      default: pat = `IAP_PAT5;
    endcase
  end

  // unlock sequence: in-order pattern into word1..word3, bounded by timeout
  always_comb begin
    unlock_ok = 1'b0;
    unlock_end = 1'b0;
    if (ustate == U_RUN) begin
      if (ucnt == ($bits(ucnt))'(UNLOCK_CYC - 1)) begin
        unlock_end = 1'b1;
      end else if (data_wr && link.offset >= `IAP_OFF_DATA1) begin
        if (link.offset == 8'(`IAP_OFF_DATA1 + uidx)
            && link.wdata == pat) begin
          unlock_ok = (uidx == `IAP_PAT_LAST);
          unlock_end = unlock_ok;
        end else begin
          unlock_end = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ustate <= U_IDLE;
      ucnt <= '0;
      uidx <= 3'h0;
    end else begin
      case (ustate)
        U_IDLE: begin
          ucnt <= '0;
          uidx <= 3'h0;
          if (unlock_en && mode == `IAP_MODE_UNLOCK) begin
            ustate <= U_RUN;
          end
        end
        U_RUN: begin
          ucnt <= ucnt + 1'b1;
          if (unlock_end) begin
            ustate <= U_IDLE;
          end else if (data_wr && link.offset >= `IAP_OFF_DATA1) begin
            uidx <= uidx + 3'h1;
          end
        end
        default: ustate <= U_IDLE;
      endcase
    end
  end

  // flash operation sequencer
  always_comb begin
    next_ostate = ostate;
    next_op_kind = op_kind;
    launch_wr = 1'b0;
    launch_er = 1'b0;
    launch_rd = 1'b0;
    launch_clr = 1'b0;
    end_wr = 1'b0;
    end_rd = 1'b0;
    end_clr = 1'b0;
    case (ostate)
      O_IDLE: begin
        if (wr_trig) begin
          if (wen_stat && mode == `IAP_MODE_WRITE) begin
            launch_wr = 1'b1;
          end else if (wen_stat && mode == `IAP_MODE_ERASE) begin
            launch_er = 1'b1;
          end else begin
            end_wr = 1'b1;
          end
          next_op_kind = 3'b001;
          next_ostate = end_wr ? O_IDLE : O_WAIT;
        end else if (rd_trig) begin
          if (rd_en && mode == `IAP_MODE_READ) begin
            launch_rd = 1'b1;
            next_ostate = O_WAIT;
          end else begin
            end_rd = 1'b1;
          end
          next_op_kind = 3'b010;
        end else if (clr_trig) begin
          launch_clr = 1'b1;
          next_op_kind = 3'b100;
          next_ostate = O_WAIT;
        end
      end
      O_WAIT: begin
        if (flash_done) begin
          end_wr = op_kind[0];
          end_rd = op_kind[1];
          end_clr = op_kind[2];
          next_ostate = O_IDLE;
        end
      end
      default: next_ostate = O_IDLE;
    endcase
  end

  // triggers: software sets, hardware clears on completion
  always_comb begin
    next_wr_trig = wr_trig;
    next_rd_trig = rd_trig;
    if (ctrl_wr && link.wdata[`IAP_BIT_WR_TRIG]) begin
      next_wr_trig = 1'b1;
    end else if (end_wr) begin
      next_wr_trig = 1'b0;
    end
    if (ctrl_wr && link.wdata[`IAP_BIT_RD_TRIG]) begin
      next_rd_trig = 1'b1;
    end else if (end_rd) begin
      next_rd_trig = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_trig <= 1'b0;
      rd_trig <= 1'b0;
      halt <= 1'b0;
    end else begin
      wr_trig <= next_wr_trig;
      rd_trig <= next_rd_trig;
      halt <= next_wr_trig | next_rd_trig;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_trig <= 1'b0;
    end else if (wr_hit && link.offset == `IAP_OFF_CLR
                 && link.wdata[`IAP_BIT_CLR_TRIG]) begin
      clr_trig <= 1'b1;
    end else if (end_clr) begin
      clr_trig <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ostate <= O_IDLE;
      op_kind <= 3'b000;
      flash_write <= 1'b0;
      flash_erase <= 1'b0;
      flash_read <= 1'b0;
      flash_clear <= 1'b0;
    end else begin
      ostate <= next_ostate;
      op_kind <= next_op_kind;
      flash_write <= launch_wr;
      flash_erase <= launch_er;
      flash_read <= launch_rd;
      flash_clear <= launch_clr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_rst <= 1'b0;
    end else begin
      chip_rst <= wr_hit && link.offset == `IAP_OFF_KEY
                  && link.wdata == `IAP_RESET_KEY;
    end
  end

  // read mux, answer one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= `IAP_BYTE_RESET;
    end else if (rd_hit) begin
      case (link.offset)
        `IAP_OFF_CTRL:
          rdata <= {wen_stat, mode, unlock_en, wr_trig, rd_en, rd_trig};
        `IAP_OFF_KEY: rdata <= key;
        `IAP_OFF_CLR: rdata <= {7'h00, clr_trig};
        `IAP_OFF_ADDR_LO: rdata <= addr_lo;
        `IAP_OFF_ADDR_HI: rdata <= {2'b00, addr_hi};
        default: begin
          if (link.offset >= `IAP_OFF_DATA0
              && link.offset <= `IAP_OFF_DATA3H) begin
            rdata <= data[data_idx];
          end else begin
            rdata <= `IAP_BYTE_RESET;
          end
        end
      endcase
    end
  end

endmodule

// ==== src/iap_host.sv ====
`timescale 1ns/1ns
`include "iap_consts.svh"

module iap_host
  import iap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  iap_link_if.host link
);

  host_state_t state;
  logic cmd_wr;
  logic [7:0] cmd_off;
  logic [7:0] cmd_data;
  logic [7:0] last_rdata;
  logic [`HOST_EV_BITS-1:0] irq_stat;
  logic [`HOST_EV_BITS-1:0] irq_mask;
  logic [`HOST_EV_BITS-1:0] ev;
  logic acc;
  logic take_cmd;
  logic mapped;
  logic sel;

  assign acc = psel & penable & pready;
  assign take_cmd = acc & pwrite & (paddr == `HOST_OFF_CMD);
  assign mapped = paddr == `HOST_OFF_CMD || paddr == `HOST_OFF_STATUS
                  || paddr == `HOST_OFF_IRQ_STAT
                  || paddr == `HOST_OFF_IRQ_MASK;

  assign link.sel = sel;
  assign link.wr = cmd_wr;
  assign link.sector = `IAP_SECTOR;
  assign link.offset = cmd_off;
  assign link.wdata = cmd_data;

  // one wait-free access phase: pready rises after the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `HOST_OFF_STATUS:
            prdata <= {16'h0000, last_rdata, 6'h00, link.cpu_halt,
                       state != H_IDLE};
          `HOST_OFF_IRQ_STAT: prdata <= 32'(irq_stat);
          `HOST_OFF_IRQ_MASK: prdata <= 32'(irq_mask);
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // register access sequencer; never strobes while the core is halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      sel <= 1'b0;
      cmd_wr <= 1'b0;
      cmd_off <= 8'h00;
      cmd_data <= 8'h00;
      last_rdata <= 8'h00;
    end else begin
      case (state)
        H_IDLE: begin
          if (take_cmd) begin
            cmd_wr <= pwdata[`HOST_CMD_WR_BIT];
            cmd_off <= pwdata[15:8];
            cmd_data <= pwdata[7:0];
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (!link.cpu_halt) begin
            sel <= 1'b1;
            state <= H_ISSUE;
          end
        end
        H_ISSUE: begin
          sel <= 1'b0;
          state <= cmd_wr ? H_IDLE : H_CAPT;
        end
        H_CAPT: begin
          last_rdata <= link.rdata;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  always_comb begin
    ev = '0;
    ev[`HOST_EV_DONE] = (state == H_ISSUE && cmd_wr) || state == H_CAPT;
    ev[`HOST_EV_CHIP_RST] = link.chip_reset;
    ev[`HOST_EV_DROP] = take_cmd && state != H_IDLE;
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == `HOST_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[`HOST_EV_BITS-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (acc && pwrite && paddr == `HOST_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[`HOST_EV_BITS-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule

// ==== dv/iap_link_assertions.sv ====
`timescale 1ns/1ns
module iap_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sel,
  input wire logic wr,
  input wire logic [7:0] sector,
  input wire logic [7:0] offset,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic cpu_halt,
  input wire logic chip_reset
);
  logic key_hit;
  assign key_hit = sel && wr && offset == 8'h44 && wdata == 8'h55;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_read;
    sel && !wr;
  endsequence
  sequence s_trig_wr;
    sel && wr && offset == 8'h43 && (wdata[2] || wdata[0]);
  endsequence
  a_sector_one: assert property (sel |-> sector == 8'h01)
    else $error("strobe outside sector one");
  a_key_pulse: assert property (key_hit |=> ##[0:1] chip_reset)
    else $error("key write gave no chip reset");
  a_key_cause: assert property (chip_reset |->
    $past(key_hit) || $past(key_hit, 2))
    else $error("chip reset without key write");
  a_reset_single: assert property (chip_reset |=> !chip_reset)
    else $error("chip reset longer than one cycle");
  a_trig_halt: assert property (s_trig_wr |=> cpu_halt)
    else $error("trigger set without halt");
  a_halt_ends: assert property ($rose(cpu_halt) |-> ##[1:100] !cpu_halt)
    else $error("halt never released");
  a_halt_no_sel: assert property (cpu_halt |-> !sel)
    else $error("strobe during halt");
  a_read_gap: assert property (s_read |=> !sel [*2])
    else $error("read strobes too close");
  a_rdata_hold: assert property (!sel |=> $stable(rdata))
    else $error("read byte changed without read");
endmodule

// ==== dv/iap_flash_control_registers_tb.sv ====
`timescale 1ns/1ns
module iap_flash_control_registers_tb;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic flash_write, flash_erase, flash_read, flash_clear, flash_done, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r, d;
  logic [13:0] flash_addr;
  logic [15:0] flash_wdata, flash_rdata, last_rd;
  logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
  int mismatches, samples_checked, n_w, n_e, n_r, n_c;
  note_t q[$];
  note_t n;
  iap_link_if link();
  iap_host u_iap_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  iap_device #(.ADDR_HI_BITS(5), .UNLOCK_CYC(200)) u_iap_device (
    .pclk(pclk), .presetn(presetn), .link(link), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_write(flash_write),
    .flash_erase(flash_erase), .flash_read(flash_read),
    .flash_clear(flash_clear), .flash_done(flash_done),
    .flash_rdata(flash_rdata));
  iap_link_assertions u_iap_link_assertions (.pclk(pclk),
    .presetn(presetn), .sel(link.sel), .wr(link.wr), .sector(link.sector),
    .offset(link.offset), .wdata(link.wdata), .rdata(link.rdata),
    .cpu_halt(link.cpu_halt), .chip_reset(link.chip_reset));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // dd is write data, or the expected read word under mask m
  task apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
    input logic [31:0] m);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? dd : 32'h0;
    if (!w)
      q.push_back(note_t'{dd, m});
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (i >= 20) begin
      mismatches++;
      end_of_test;
    end
  endtask
  task dev(input logic w, input logic [7:0] off, input logic [7:0] dv);
    int i;
    apb(1, 12'h000, {7'h00, w, 8'h00, off, dv}, 32'h0);
    i = 0;
    do begin
      apb(0, 12'h004, 32'h0, 32'h0);
      i++;
    end while (r[0] !== 1'b0 && i < 40);
    if (i >= 40) begin
      mismatches++;
      end_of_test;
    end
  endtask
  task rd(input logic [7:0] off, input logic [7:0] x);
    dev(0, off, 8'h00);
    apb(0, 12'h004, {16'h0000, x, 8'h00}, 32'h0000FF00);
  endtask
  task unlock(input logic [7:0] bad, input int gap);
    dev(1, 8'h43, 8'h68);
    repeat (gap) @(posedge pclk);
    for (int i = 0; i < 6; i++)
      dev(1, 8'h4A + 8'(i), pat[i] ^ (i == 5 ? bad : 8'h00));
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      n = q.pop_front();
      if (n.m != 32'h0)
        check("prdata", prdata & n.m, n.v & n.m);
    end
  end
  // flash array: answers next cycle, data pattern moves every cycle
  always @(posedge pclk) begin
    flash_done <= (flash_write | flash_erase | flash_read | flash_clear);
    flash_rdata <= {flash_rdata[14:0], ~flash_rdata[15]};
    if (flash_done === 1'b1)
      last_rd = flash_rdata;
    if (flash_write === 1'b1) n_w++;
    if (flash_erase === 1'b1) n_e++;
    if (flash_read === 1'b1) n_r++;
    if (flash_clear === 1'b1) n_c++;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, flash_done, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    flash_rdata = 16'hA5C3;
    seed = 32'd16708;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    for (int o = 8'h43; o < 8'h50; o++)
      rd(8'(o), 8'h00);
    dev(1, 8'h47, 8'hFF);
    rd(8'h47, 8'h1F);
    d = rnd();
    dev(1, 8'h46, d[7:0]);
    check("flash_addr", {18'h0, flash_addr}, {18'h0, 6'h1F, d[7:0]});
    dev(1, 8'h45, 8'hFF);
    rd(8'h45, 8'h00);
    check("clear pulses", n_c, 1);
    dev(1, 8'h44, 8'hAA);
    rd(8'h44, 8'hAA);
    dev(1, 8'h43, 8'h84);
    rd(8'h43, 8'h00);
    check("locked writes", n_w, 0);
    unlock(8'h01, 0);
    rd(8'h43, 8'h60);
    unlock(8'h00, 250);
    rd(8'h43, 8'h60);
    unlock(8'h00, 0);
    rd(8'h43, 8'hE0);
    d = rnd();
    dev(1, 8'h48, d[7:0]);
    dev(1, 8'h49, d[15:8]);
    for (int m = 0; m < 8; m++) begin
      dev(1, 8'h43, {1'b1, 3'(m), 4'h4});
      rd(8'h43, {1'b1, 3'(m), 4'h0});
    end
    check("write pulses", n_w, 1);
    check("erase pulses", n_e, 1);
    check("flash_wdata", {16'h0, flash_wdata}, {16'h0, d[15:0]});
    dev(1, 8'h43, 8'hB3);
    rd(8'h43, 8'hB2);
    rd(8'h48, last_rd[7:0]);
    rd(8'h49, last_rd[15:8]);
    dev(1, 8'h43, 8'h31);
    rd(8'h43, 8'h30);
    check("read pulses", n_r, 1);
    dev(1, 8'h43, 8'h04);
    check("unlocked writes", n_w, 1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1, 12'h00C, 32'h2, 32'h0);
    dev(1, 8'h44, 8'h55);
    repeat (3) @(posedge pclk);
    check("irq raised", {31'h0, irq}, 32'h1);
    apb(0, 12'h008, 32'h3, 32'h7);
    apb(1, 12'h008, 32'h7, 32'h0);
    repeat (3) @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // second command lands while the first read is still in flight
    apb(1, 12'h000, 32'h0000_4400, 32'h0);
    apb(1, 12'h000, 32'h0100_44AA, 32'h0);
    apb(0, 12'h008, 32'h4, 32'h4);
    rd(8'h44, 8'h55);
    apb(0, 12'h010, 32'h0, 32'h0);
    check("pslverr", {31'h0, e}, 32'h1);
    end_of_test;
  end
endmodule
